// *** logic/txim_pkg.sv ***
// Package: register map, field layout and reset values of the transmit interrupt mask block
//
// How it works
// - Each transmit channel 0 to 7 has a raw pending flag held in a register and readable before masking.
// - The masked status register shows in bit n each transmit channel's pending flag after its enable mask.
// - Writing a one to bit n of the enable set register enables the interrupt of transmit channel n.
// - Zero bits written to the enable set register leave the enable mask bits as they were.
// - Writing a one to bit n of the enable clear register disables the interrupt of transmit channel n.
// - Zero bits written to the enable clear register leave the enable mask bits as they were.
// - Bit 31 of the input vector shows the management unit user interrupt pending.
// - Bit 30 of the input vector shows the management unit link change interrupt pending.
// - Bit 17 of the input vector shows the host error interrupt pending.
// - Bit 16 of the input vector shows the statistics interrupt pending.
// - Bits 15 to 8 of the input vector carry the receive channel flags, bit 8 being receive channel 0.
// - Bits 7 to 0 of the input vector carry the transmit channel flags, bit 0 being transmit channel 0.
`default_nettype none
package txim_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CH_N = 8;
    localparam logic [ADDR_W-1:0] OFF_TX_RAW = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_TX_MASKED = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_TX_EN_SET = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_TX_EN_CLR = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_IN_VECTOR = 8'h10;
    localparam logic [CH_N-1:0] MASK_RST = 8'h00;
    localparam logic [CH_N-1:0] PEND_RST = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h00000000;
    localparam int VEC_USER_BIT = 31;
    localparam int VEC_LINK_BIT = 30;
    localparam int VEC_RSV_HI = 29;
    localparam int VEC_RSV_LO = 18;
    localparam int VEC_HOST_BIT = 17;
    localparam int VEC_STAT_BIT = 16;
    localparam int VEC_RX_LSB = 8;
    localparam int VEC_TX_LSB = 0;
endpackage
`default_nettype wire

// *** logic/txim_mask_if.sv ***
// Interface: enable mask set and clear requests and the resulting mask
`timescale 1ns/10ps
`default_nettype none
interface txim_mask_if #(
    parameter int CH = 8
);
    logic [CH-1:0] set_bits;
    logic [CH-1:0] clr_bits;
    logic [CH-1:0] mask;
    modport ctrl (
        output set_bits,
        output clr_bits,
        input mask
    );
    modport bank (
        input set_bits,
        input clr_bits,
        output mask
    );
endinterface
`default_nettype wire

// *** logic/txim_mask_bank.sv ***
// Enable mask bank with write-one-to-set and write-one-to-clear
`timescale 1ns/10ps
`default_nettype none
module txim_mask_bank #(
    parameter int CH = 8
) (
    input wire logic clk,
    input wire logic reset,
    txim_mask_if.bank mif
);
    logic [CH-1:0] mask_reg;
    logic [CH-1:0] mask_next;

    // Ones set or clear, zeros keep; set wins if both arrive together
    assign mask_next = (mask_reg & ~mif.clr_bits) | mif.set_bits;
    assign mif.mask = mask_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mask_reg <= txim_pkg::MASK_RST;
        end else begin
            mask_reg <= mask_next;
        end
    end
endmodule
`default_nettype wire

// *** logic/txim_capture.sv ***
// Pending flag capture and input vector packing
`timescale 1ns/10ps
`default_nettype none
module txim_capture #(
    parameter int CH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [CH-1:0] tx_channel_pending,
    input wire logic [CH-1:0] rx_channels_pending,
    input wire logic host_error_pending,
    input wire logic statistics_irq_pending,
    input wire logic mgmt_user_irq_pending,
    input wire logic mgmt_link_change_pending,
    output logic [CH-1:0] tx_pend,
    output logic [txim_pkg::DATA_W-1:0] vector
);
    logic [CH-1:0] tx_pend_reg;
    logic [CH-1:0] rx_pend_reg;
    logic [3:0] misc_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_pend_reg <= txim_pkg::PEND_RST;
            rx_pend_reg <= txim_pkg::PEND_RST;
            misc_reg <= 4'h0;
        end else begin
            tx_pend_reg <= tx_channel_pending;
            rx_pend_reg <= rx_channels_pending;
            misc_reg <= {mgmt_user_irq_pending, mgmt_link_change_pending,
                         host_error_pending, statistics_irq_pending};
        end
    end

    assign tx_pend = tx_pend_reg;
    assign vector[txim_pkg::VEC_USER_BIT] = misc_reg[3];
    assign vector[txim_pkg::VEC_LINK_BIT] = misc_reg[2];
    assign vector[txim_pkg::VEC_RSV_HI:txim_pkg::VEC_RSV_LO] = '0;
    assign vector[txim_pkg::VEC_HOST_BIT] = misc_reg[1];
    assign vector[txim_pkg::VEC_STAT_BIT] = misc_reg[0];
    assign vector[txim_pkg::VEC_RX_LSB +: CH] = rx_pend_reg;
    assign vector[txim_pkg::VEC_TX_LSB +: CH] = tx_pend_reg;
endmodule
`default_nettype wire

// *** logic/txim_top.sv ***
// Top: register port, transmit interrupt masking and input vector readback
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module txim_top #(
    parameter int CH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [txim_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [txim_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [txim_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [CH-1:0] tx_channel_pending,
    input wire logic [CH-1:0] rx_channels_pending,
    input wire logic host_error_pending,
    input wire logic statistics_irq_pending,
    input wire logic mgmt_user_irq_pending,
    input wire logic mgmt_link_change_pending,
    output logic [CH-1:0] tx_masked_irq_status
);
    localparam int DATA_W = txim_pkg::DATA_W;

    logic [txim_pkg::DATA_W-1:0] rdata_reg;
    logic [txim_pkg::DATA_W-1:0] rdata_next;
    logic [CH-1:0] masked_reg;
    logic [CH-1:0] masked_w;
    logic [CH-1:0] tx_pend_w;
    logic [txim_pkg::DATA_W-1:0] vector_w;
    logic sel_raw;
    logic sel_masked;
    logic sel_set;
    logic sel_clr;
    logic sel_vec;
    logic [txim_pkg::DATA_W-1:0] raw_word;
    logic [txim_pkg::DATA_W-1:0] masked_word;
    logic [txim_pkg::DATA_W-1:0] mask_word;

    txim_mask_if #(.CH(CH)) mif ();

    txim_mask_bank #(.CH(CH)) u_bank (
        .clk(clk),
        .reset(reset),
        .mif(mif.bank)
    );

    txim_capture #(.CH(CH)) u_cap (
        .clk(clk),
        .reset(reset),
        .tx_channel_pending(tx_channel_pending),
        .rx_channels_pending(rx_channels_pending),
        .host_error_pending(host_error_pending),
        .statistics_irq_pending(statistics_irq_pending),
        .mgmt_user_irq_pending(mgmt_user_irq_pending),
        .mgmt_link_change_pending(mgmt_link_change_pending),
        .tx_pend(tx_pend_w),
        .vector(vector_w)
    );

    // Address decode
    assign sel_raw = (reg_addr == txim_pkg::OFF_TX_RAW);
    assign sel_masked = (reg_addr == txim_pkg::OFF_TX_MASKED);
    assign sel_set = (reg_addr == txim_pkg::OFF_TX_EN_SET);
    assign sel_clr = (reg_addr == txim_pkg::OFF_TX_EN_CLR);
    assign sel_vec = (reg_addr == txim_pkg::OFF_IN_VECTOR);

    // Only the low channel bits reach the mask; upper bits are dropped
    assign mif.set_bits = (reg_wr && sel_set) ? reg_wdata[CH-1:0] : '0;
    assign mif.clr_bits = (reg_wr && sel_clr) ? reg_wdata[CH-1:0] : '0;

    // Masking
    assign masked_w = tx_pend_w & mif.mask;

    // Readback words, reserved bits zero
    assign raw_word = DATA_W'(tx_pend_w);
    assign masked_word = DATA_W'(masked_w);
    assign mask_word = DATA_W'(mif.mask);

    // Read mux; unmapped or write-only-free addresses read zero
    assign rdata_next = !reg_rd ? txim_pkg::RDATA_RST :
                        sel_raw ? raw_word :
                        sel_masked ? masked_word :
                        (sel_set || sel_clr) ? mask_word :
                        sel_vec ? vector_w :
                        txim_pkg::RDATA_RST;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_reg <= txim_pkg::RDATA_RST;
            masked_reg <= txim_pkg::MASK_RST;
        end else begin
            rdata_reg <= rdata_next;
            masked_reg <= masked_w;
        end
    end

    assign reg_rdata = rdata_reg;
    assign tx_masked_irq_status = masked_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    AST_SET_ENABLES: assert property (
        (reg_wr && sel_set)
        |=> ((mif.mask & $past(reg_wdata[CH-1:0])) == $past(reg_wdata[CH-1:0]))
    ) else $error("Set write did not enable the written channels");

    AST_SET_ZERO_KEEPS: assert property (
        (reg_wr && sel_set)
        |=> ((mif.mask & ~$past(reg_wdata[CH-1:0])) == ($past(mif.mask) & ~$past(reg_wdata[CH-1:0])))
    ) else $error("Set write changed a channel written with zero");

    AST_CLR_DISABLES: assert property (
        (reg_wr && sel_clr)
        |=> ((mif.mask & $past(reg_wdata[CH-1:0])) == '0)
    ) else $error("Clear write left a written channel enabled");

    AST_CLR_ZERO_KEEPS: assert property (
        (reg_wr && sel_clr)
        |=> ((mif.mask & ~$past(reg_wdata[CH-1:0])) == ($past(mif.mask) & ~$past(reg_wdata[CH-1:0])))
    ) else $error("Clear write changed a channel written with zero");

    AST_MASK_HOLDS: assert property (
        !(reg_wr && (sel_set || sel_clr)) |=> $stable(mif.mask)
    ) else $error("Enable mask moved without a set or clear write");

    AST_MASKED_AND: assert property (
        tx_masked_irq_status == ($past(tx_pend_w) & $past(mif.mask))
    ) else $error("Masked status output is not pending AND enable");

    AST_MASKED_READ: assert property (
        (reg_rd && sel_masked)
        |=> (reg_rdata == DATA_W'($past(tx_pend_w) & $past(mif.mask)))
    ) else $error("Masked status read returned the wrong value");

    AST_RAW_READ: assert property (
        (reg_rd && sel_raw) |=> (reg_rdata == DATA_W'($past(tx_pend_w)))
    ) else $error("Raw status read returned the wrong value");

    AST_RAW_FOLLOWS_PIN: assert property (
        !reset |=> (tx_pend_w == $past(tx_channel_pending))
    ) else $error("Raw pending flags do not follow the inputs by one cycle");

    AST_VEC_MGMT: assert property (
        (reg_rd && sel_vec)
        |=> (reg_rdata[txim_pkg::VEC_USER_BIT] == $past(mgmt_user_irq_pending, 2))
    ) else $error("Vector user interrupt bit wrong");

    AST_VEC_LINK: assert property (
        ##1 (reg_rd && sel_vec)
        |=> (reg_rdata[txim_pkg::VEC_LINK_BIT] == $past(mgmt_link_change_pending, 2))
    ) else $error("Vector link change bit wrong");

    AST_VEC_HOST_STAT: assert property (
        ##1 (reg_rd && sel_vec)
        |=> (reg_rdata[txim_pkg::VEC_HOST_BIT] == $past(host_error_pending, 2))
            && (reg_rdata[txim_pkg::VEC_STAT_BIT] == $past(statistics_irq_pending, 2))
    ) else $error("Vector host error or statistics bit wrong");

    AST_VEC_CHANNELS: assert property (
        ##1 (reg_rd && sel_vec)
        |=> (reg_rdata[txim_pkg::VEC_RX_LSB +: CH] == $past(rx_channels_pending, 2))
            && (reg_rdata[txim_pkg::VEC_TX_LSB +: CH] == $past(tx_channel_pending, 2))
    ) else $error("Vector channel fields wrong");

    AST_RESERVED_ZERO: assert property (
        (reg_rdata[txim_pkg::VEC_RSV_HI:txim_pkg::VEC_RSV_LO] == '0)
        && ($past(reg_rd && sel_vec) || (reg_rdata[DATA_W-1:CH] == '0))
    ) else $error("Reserved bits read non-zero");

    AST_RDATA_ONE_CYCLE: assert property (
        !reg_rd |=> (reg_rdata == '0)
    ) else $error("Read data present without a read");

    AST_RESET_CLEARS: assert property (
        @(posedge clk) disable iff (1'b0)
        $fell(reset) |-> (mif.mask == '0) && (tx_masked_irq_status == '0)
    ) else $error("Mask or masked status not zero after reset");

    COV_SET_THEN_CLR: cover property (
        (reg_wr && sel_set && (reg_wdata[CH-1:0] != '0)) ##[1:4] (reg_wr && sel_clr)
    );

    COV_MASKED_HIT: cover property (
        (reg_rd && sel_masked) ##1 (reg_rdata != '0)
    );

    COV_VECTOR_READ: cover property (
        (reg_rd && sel_vec) ##1 reg_rdata[txim_pkg::VEC_USER_BIT]
    );

    COV_BACK_TO_BACK: cover property (
        (reg_wr && sel_set) ##1 (reg_rd && sel_masked)
    );
endmodule
`default_nettype wire

// *** bench/txim_tb.sv ***
// Testbench for the transmit interrupt mask and input vector block
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [txim_pkg::ADDR_W-1:0] reg_addr = 8'h00;
    logic [txim_pkg::DATA_W-1:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [txim_pkg::DATA_W-1:0] reg_rdata;
    logic [7:0] tx_pend = 8'h00;
    logic [7:0] rx_pend = 8'h00;
    logic host_err = 1'b0;
    logic stat_irq = 1'b0;
    logic user_irq = 1'b0;
    logic link_irq = 1'b0;
    logic [7:0] tx_masked;
    int n_mismatch = 0;
    int num_checks = 0;

    always #2.5 clk = ~clk;

    txim_top #(.CH(8)) uut (
        .clk(clk),
        .reset(reset),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .tx_channel_pending(tx_pend),
        .rx_channels_pending(rx_pend),
        .host_error_pending(host_err),
        .statistics_irq_pending(stat_irq),
        .mgmt_user_irq_pending(user_irq),
        .mgmt_link_change_pending(link_irq),
        .tx_masked_irq_status(tx_masked)
    );

    task results;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data is looked at in the single cycle after the strobe
    task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask

    // Drives all pending sources from one vector-shaped word, then lets them settle
    task vec(input logic [31:0] v);
        @(posedge clk);
        user_irq <= v[31];
        link_irq <= v[30];
        host_err <= v[17];
        stat_irq <= v[16];
        rx_pend <= v[15:8];
        tx_pend <= v[7:0];
        repeat (3) @(posedge clk);
    endtask

    task t_reset;
        rd(8'h04, 32'h00000000, "masked after reset");
        rd(8'h08, 32'h00000000, "mask after reset");
        rd(8'h10, 32'h00000000, "vector idle");
        chk("masked output after reset", 32'h00000000, {24'h000000, tx_masked});
    endtask

    task t_raw_and_set;
        vec(32'h000000A5);
        rd(8'h00, 32'h000000A5, "raw status");
        rd(8'h04, 32'h00000000, "masked with mask off");
        wr(8'h08, 32'hFFFFFF0F);
        rd(8'h08, 32'h0000000F, "mask after set");
        rd(8'h04, 32'h00000005, "masked after set");
        chk("masked output after set", 32'h00000005, {24'h000000, tx_masked});
        wr(8'h08, 32'h00000000);
        rd(8'h0C, 32'h0000000F, "mask after zero set");
        wr(8'h08, 32'h00000030);
        rd(8'h08, 32'h0000003F, "mask after partial set");
    endtask

    task t_clear;
        wr(8'h0C, 32'hFFFFFF05);
        rd(8'h0C, 32'h0000003A, "mask after clear");
        wr(8'h0C, 32'h00000000);
        rd(8'h08, 32'h0000003A, "mask after zero clear");
        rd(8'h04, 32'h00000020, "masked after clear");
    endtask

    // Walks every channel through clear and set one bit at a time
    task t_walk;
        logic [7:0] m;
        wr(8'h08, 32'h000000FF);
        for (int n = 0; n < 8; n++) begin
            m = 8'hFF << (n + 1);
            wr(8'h0C, 32'h00000001 << n);
            rd(8'h0C, {24'h000000, m}, "mask walking clear");
        end
        for (int n = 0; n < 8; n++) begin
            m = m | (8'h01 << n);
            wr(8'h08, 32'h00000001 << n);
            rd(8'h04, {24'h000000, m & 8'hA5}, "masked walking set");
            chk("masked output walking", {24'h000000, m & 8'hA5}, {24'h000000, tx_masked});
        end
    endtask

    task t_refused;
        wr(8'h00, 32'hFFFFFFFF);
        wr(8'h04, 32'hFFFFFFFF);
        wr(8'h10, 32'hFFFFFFFF);
        wr(8'h20, 32'hFFFFFFFF);
        rd(8'h08, 32'h000000FF, "mask after ignored writes");
        rd(8'h20, 32'h00000000, "unmapped read");
        rd(8'h00, 32'h000000A5, "raw after ignored writes");
    endtask

    // Reset in mid-run clears the enable mask and the raw flags, which follow the inputs again once reset ends
    task t_reset_again;
        chk("masked output before reset", 32'h000000A5, {24'h000000, tx_masked});
        @(posedge clk);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk("masked output in reset", 32'h00000000, {24'h000000, tx_masked});
        rd(8'h08, 32'h00000000, "mask after second reset");
        rd(8'h04, 32'h00000000, "masked after second reset");
        rd(8'h00, 32'h000000A5, "raw after second reset");
        chk("masked output after second reset", 32'h00000000, {24'h000000, tx_masked});
    endtask

    task t_vector;
        logic [31:0] pat [0:9];
        pat = '{32'h80000000, 32'h40000000, 32'h00020000, 32'h00010000, 32'h00000100,
                32'h00008000, 32'h00000001, 32'h00000080, 32'hFFFFFFFF, 32'h00000000};
        for (int i = 0; i < 10; i++) begin
            vec(pat[i]);
            rd(8'h10, pat[i] & 32'hC003FFFF, "input vector");
        end
    endtask

    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_raw_and_set();
        t_clear();
        t_walk();
        t_refused();
        t_reset_again();
        t_vector();
        results();
    end

    initial begin
        #25000;
        n_mismatch++;
        results();
    end
endmodule
`default_nettype wire
